/* File: bench/increment_skip_instr_exec_bench.sv */
// Self-checking bench for the increment execute block.
// Assumes the checker file is compiled before this one.
`timescale 1ns/1ps
module increment_skip_instr_exec_bench;
  // One expected write-back with its side effects
  typedef struct packed {
    logic to_file;
    logic [7:0] data;
    logic [11:0] addr;
    logic stat;
    logic [4:0] flags;
    logic disc;
    logic [3:0] nclk;
  } note_s;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic instr_valid_i = 1'b0;
  logic [15:0] instr_i = 16'h0000;
  logic next_two_word_i = 1'b0;
  logic [3:0] bank_select_pointer_i = 4'h0;
  logic ext_set_en_i = 1'b0;
  logic [11:0] index_base_i = 12'h000;
  logic [7:0] file_rdata_i = 8'h00;
  logic [1:0] phase_o;
  logic [11:0] file_addr_o;
  logic [7:0] file_wdata_o, wreg_data_o;
  logic file_rd_o, file_we_o, wreg_we_o, status_we_o, discard_o, nop_cycle_o;
  logic carry_flag_o, digit_carry_flag_o, negative_flag_o, overflow_flag_o, zero_flag_o;
  logic [7:0] mem [0:4095];
  logic [31:0] lfsr_r = 32'h0001352E;
  logic [4:0] flags_r = 5'h00;
  note_s notes[$];
  int num_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #20 clk_i = ~clk_i;

  increment_skip_instr_exec increment_skip_instr_exec_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .next_two_word_i(next_two_word_i),
    .bank_select_pointer_i(bank_select_pointer_i), .ext_set_en_i(ext_set_en_i), .index_base_i(index_base_i),
    .file_rdata_i(file_rdata_i), .phase_o(phase_o), .file_addr_o(file_addr_o), .file_rd_o(file_rd_o),
    .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .wreg_we_o(wreg_we_o), .wreg_data_o(wreg_data_o),
    .status_we_o(status_we_o), .carry_flag_o(carry_flag_o), .digit_carry_flag_o(digit_carry_flag_o),
    .negative_flag_o(negative_flag_o), .overflow_flag_o(overflow_flag_o), .zero_flag_o(zero_flag_o),
    .discard_o(discard_o), .nop_cycle_o(nop_cycle_o));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude

  // Present one opcode at Q1; ctl is bank, ext, two-word, a, d
  task automatic issue(input logic [5:0] op, input logic [7:0] f, input logic [7:0] v, input logic [7:0] ctl,
                       input logic [11:0] base);
    logic [11:0] addr;
    logic [7:0] res;
    logic skip;
    addr = ctl[1] ? {ctl[7:4], f} : (ctl[3] && f <= 8'h5F) ? base + {4'h0, f} : {(f <= 8'h5F) ? 4'h0 : 4'hF, f};
    res = v + 8'h01;
    skip = (op == 6'h0F && res == 8'h00) || (op == 6'h12 && res != 8'h00);
    if (op == 6'h0A) flags_r = {v == 8'hFF, v[3:0] == 4'hF, res[7], v == 8'h7F, res == 8'h00};
    mem[addr] = v;
    if (op inside {6'h0A, 6'h0F, 6'h12})
      notes.push_back({ctl[0], res, addr, op == 6'h0A, flags_r, skip, skip ? (ctl[2] ? 4'h8 : 4'h4) : 4'h0});
    {instr_valid_i, instr_i, next_two_word_i} = {1'b1, op, ctl[0], ctl[1], f, ctl[2]};
    {bank_select_pointer_i, ext_set_en_i, index_base_i} = {ctl[7:4], ctl[3], base};
    @(negedge clk_i);
    instr_valid_i = 1'b0;
    repeat (3) @(negedge clk_i);
    // Opcodes offered inside the no-operation span must be ignored
    repeat (skip ? (ctl[2] ? 2 : 1) : 0) begin
      {instr_valid_i, instr_i} = {1'b1, 6'h0A, 10'h155};
      @(negedge clk_i);
      instr_valid_i = 1'b0;
      repeat (3) @(negedge clk_i);
    end
  endtask : issue

  // File memory answers the read strobe and holds the byte
  always @(negedge clk_i) if (file_rd_o === 1'b1) file_rdata_i <= mem[file_addr_o];

  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      num_errors++;
      conclude();
    end
  end

  // Watcher: each write strobe retires the oldest note
  initial begin : watch
    note_s n;
    int k;
    forever begin
      @(negedge clk_i);
      if (file_we_o === 1'b1 || wreg_we_o === 1'b1) begin
        check("pending", notes.size() != 0, 1);
        n = notes.pop_front();
        check("dest", {file_we_o, wreg_we_o}, {n.to_file, !n.to_file});
        check("data", n.to_file ? file_wdata_o : wreg_data_o, n.data);
        check("addr", file_addr_o, n.addr);
        check("status", status_we_o, n.stat);
        check("flags", {carry_flag_o, digit_carry_flag_o, negative_flag_o, overflow_flag_o, zero_flag_o}, n.flags);
        check("discard", discard_o, n.disc);
        k = 0;
        while (nop_cycle_o === 1'b1 && k < 12) begin
          k++;
          @(negedge clk_i);
        end
        check("nops", k, n.nclk);
      end
    end
  end

  // Main sequence: directed table, refused opcodes, random run
  initial begin : run
    logic [31:0] r;
    logic [7:0] vals [5];
    logic [5:0] ops [3];
    vals = '{8'hFF, 8'h7F, 8'h0F, 8'h00, 8'h5E};
    ops = '{6'h0A, 6'h0F, 6'h12};
    repeat (6) @(negedge clk_i);
    rst_b_i = 1'b1;
    while (phase_o !== 2'h0) @(negedge clk_i);
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 5; j++) begin
        issue(ops[i], 8'h60 - 8'(j), vals[j], {4'(i + j), j[1], j[0], j[2], j[0] ^ i[0]}, 12'hA40);
      end
    end
    issue(6'h0B, 8'h10, 8'h33, 8'h01, 12'h000);
    issue(6'h13, 8'h11, 8'hFF, 8'h00, 12'h000);
    for (int t = 0; t < 40; t++) begin
      lfsr_r = lfsr_next(lfsr_r);
      r = lfsr_r;
      issue(ops[int'(r[1:0]) % 3], r[15:8], r[2] ? 8'hFF : r[31:24], r[23:16], r[27:16]);
    end
    repeat (12) @(negedge clk_i);
    check("leftover", notes.size(), 0);
    conclude();
  end
endmodule : increment_skip_instr_exec_bench

bind increment_skip_instr_exec increment_skip_instr_exec_properties #(.ADDR_W(ADDR_W)) props_inst (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
  .bank_select_pointer_i(bank_select_pointer_i), .ext_set_en_i(ext_set_en_i), .index_base_i(index_base_i),
  .file_rdata_i(file_rdata_i), .phase_o(phase_o), .file_addr_o(file_addr_o), .file_rd_o(file_rd_o),
  .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .wreg_we_o(wreg_we_o), .wreg_data_o(wreg_data_o),
  .status_we_o(status_we_o), .carry_flag_o(carry_flag_o), .zero_flag_o(zero_flag_o),
  .discard_o(discard_o), .nop_cycle_o(nop_cycle_o));

/* File: bench/increment_skip_instr_exec_properties.sv */
// Port checker for the increment and increment-skip execute block.
// Assumes a bind onto the top module; sees only its ports.
`timescale 1ns/1ps
module increment_skip_instr_exec_properties #(
  parameter int ADDR_W = 12
) (
  // Inputs of the block
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic [3:0] bank_select_pointer_i,
  input wire logic ext_set_en_i,
  input wire logic [ADDR_W-1:0] index_base_i,
  input wire logic [7:0] file_rdata_i,
  // Outputs of the block
  input wire logic [1:0] phase_o,
  input wire logic [ADDR_W-1:0] file_addr_o,
  input wire logic file_rd_o,
  input wire logic file_we_o,
  input wire logic [7:0] file_wdata_o,
  input wire logic wreg_we_o,
  input wire logic [7:0] wreg_data_o,
  input wire logic status_we_o,
  input wire logic carry_flag_o,
  input wire logic zero_flag_o,
  input wire logic discard_o,
  input wire logic nop_cycle_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Opcode field and acceptance of a request
  wire logic [5:0] op_w = instr_i[15:10];
  wire logic take_w = phase_o == 2'h0 && instr_valid_i && !nop_cycle_o && op_w inside {6'h0A, 6'h0F, 6'h12};
  wire logic low_w = instr_i[7:0] <= 8'h5F;
  // Expected effective address
  wire logic [ADDR_W-1:0] addr_calc = instr_i[8] ? ADDR_W'({bank_select_pointer_i, instr_i[7:0]}) :
    (ext_set_en_i && low_w) ? index_base_i + ADDR_W'(instr_i[7:0]) : ADDR_W'({low_w ? 4'h0 : 4'hF, instr_i[7:0]});

  AST_PHASE_STEP: assert property ($past(rst_b_i) |-> phase_o == $past(phase_o) + 2'h1)
    else $error("quarter phase did not advance");
  AST_READ_STROBE: assert property (take_w |-> ##2 file_rd_o && phase_o == 2'h2)
    else $error("accepted opcode gave no read in Q3");
  AST_READ_Q3: assert property (file_rd_o |-> phase_o == 2'h2)
    else $error("read strobe outside Q3");
  AST_ADDR: assert property (take_w |-> ##2 file_addr_o == $past(addr_calc, 2))
    else $error("wrong effective address");
  AST_DEST: assert property (take_w |-> ##4 file_we_o == $past(instr_i[9], 4) && wreg_we_o != $past(instr_i[9], 4))
    else $error("wrong destination strobe");
  AST_SUM: assert property (take_w |-> ##4 (file_we_o ? file_wdata_o : wreg_data_o) == $past(file_rdata_i) + 8'h01)
    else $error("result is not operand plus one");
  AST_STATUS: assert property (take_w |-> ##4 status_we_o == ($past(op_w, 4) == 6'h0A))
    else $error("status write on wrong opcode");
  AST_SKIP: assert property (take_w && op_w != 6'h0A |->
    ##4 discard_o == (($past(op_w, 4) == 6'h0F) == ($past(file_rdata_i) == 8'hFF)))
    else $error("discard decision wrong");
  AST_NOP_SPAN: assert property ($rose(nop_cycle_o) |-> discard_o && phase_o == 2'h0 ##1 nop_cycle_o [*3])
    else $error("inserted no-operation span too short");
  AST_NOP_END: assert property ($fell(nop_cycle_o) |-> phase_o == 2'h0)
    else $error("no-operation span ended mid cycle");
  AST_FLAG_WRAP: assert property (take_w && op_w == 6'h0A |->
    ##4 zero_flag_o == carry_flag_o && carry_flag_o == ($past(file_rdata_i) == 8'hFF))
    else $error("zero or carry flag wrong");
endmodule : increment_skip_instr_exec_properties

/* File: design/inc_exec_pkg.sv */
// Types shared by the increment execute block.
// Assumes nothing beyond a SystemVerilog compiler.
package inc_exec_pkg;

  // ----------------------------------------
  // Quarter phases of one instruction cycle
  // ----------------------------------------
  typedef enum logic [1:0] {
    Q1,
    Q2,
    Q3,
    Q4
  } quarter_e;

  // ----------------------------------------
  // Decoded operation kinds
  // ----------------------------------------
  typedef enum logic [1:0] {
    OP_NONE,
    OP_INC,
    OP_INC_SKIP_Z,
    OP_INC_SKIP_NZ
  } op_e;

endpackage : inc_exec_pkg

/* File: design/inc_exec_regs.svh */
// Constants for the increment and increment-skip execute block.
// Assumes inclusion by both design modules; definitions only.
`ifndef INC_EXEC_REGS_SVH
`define INC_EXEC_REGS_SVH

// ----------------------------------------
// Opcode fields
// ----------------------------------------
`define OPC_HI_MSB 15
`define OPC_HI_LSB 10
`define OPC_D_BIT 9
`define OPC_A_BIT 8
`define OPC_F_MSB 7
`define OPC_INC_FILE 6'h0A
`define OPC_INC_SKIP_Z 6'h0F
`define OPC_INC_SKIP_NZ 6'h12

// ----------------------------------------
// Addressing constants
// ----------------------------------------
`define IDX_LIMIT 8'h5F
`define ACC_LOW_LIMIT 8'h5F
`define ACC_LOW_BANK 4'h0
`define ACC_HIGH_BANK 4'hF

// ----------------------------------------
// Data and count constants
// ----------------------------------------
`define DATA_ONE 8'h01
`define DATA_ZERO 8'h00
`define NIB_FULL 4'hF
`define BYTE_FULL 8'hFF
`define SIGNED_MAX 8'h7F
`define SKIP_ONE 2'h1
`define SKIP_TWO 2'h2
`define SKIP_NONE 2'h0

`endif

/* File: design/increment_datapath.sv */
// Address former and incrementer with status flag results.
// Assumes its inputs are stable across the quarter that samples them.
`timescale 1ns/1ps
`include "inc_exec_regs.svh"

module increment_datapath #(
  parameter int ADDR_W = 12
) (
  // Operand fields
  input wire logic [7:0] file_off_i,
  input wire logic bank_acc_i,
  input wire logic [3:0] bank_sel_i,
  input wire logic ext_set_en_i,
  input wire logic [ADDR_W-1:0] index_base_i,
  // Operand data
  input wire logic [7:0] operand_i,
  // Results
  output logic [ADDR_W-1:0] addr_o,
  output logic [7:0] sum_o,
  output logic carry_o,
  output logic digit_carry_o,
  output logic negative_o,
  output logic overflow_o,
  output logic zero_o
);

  // ----------------------------------------
  // Address selection
  // ----------------------------------------
  // Indexed mode needs extended set, access bank, low offset
  wire logic indexed = ext_set_en_i && !bank_acc_i && (file_off_i <= `IDX_LIMIT);
  // Access bank splits into low RAM and high special area
  wire logic [3:0] acc_bank = (file_off_i <= `ACC_LOW_LIMIT) ? `ACC_LOW_BANK : `ACC_HIGH_BANK;
  // Banked form taken from the bank select pointer
  wire logic [ADDR_W-1:0] banked = ADDR_W'({bank_sel_i, file_off_i});
  wire logic [ADDR_W-1:0] access = ADDR_W'({acc_bank, file_off_i});
  wire logic [ADDR_W-1:0] idx_addr = index_base_i + ADDR_W'(file_off_i);

  assign addr_o = indexed ? idx_addr : (bank_acc_i ? banked : access);

  // ----------------------------------------
  // Increment and flags
  // ----------------------------------------
  // add one
  assign sum_o = operand_i + `DATA_ONE;
  assign carry_o = (operand_i == `BYTE_FULL);
  assign digit_carry_o = (operand_i[3:0] == `NIB_FULL);
  assign negative_o = sum_o[7];
  assign overflow_o = (operand_i == `SIGNED_MAX);
  assign zero_o = (sum_o == `DATA_ZERO);

endmodule : increment_datapath

/* File: design/increment_skip_instr_exec.sv */
// Execute logic for the increment, increment-skip-zero and
// increment-skip-nonzero byte instructions.
// Assumes the fetch logic presents one opcode per instruction cycle
// at Q1, and that file memory returns read data by Q3.
`timescale 1ns/1ps
`include "inc_exec_regs.svh"

module increment_skip_instr_exec #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Instruction from fetch
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic next_two_word_i,
  // Addressing context
  input wire logic [3:0] bank_select_pointer_i,
  input wire logic ext_set_en_i,
  input wire logic [ADDR_W-1:0] index_base_i,
  // File memory read data
  input wire logic [7:0] file_rdata_i,
  // Quarter phase
  output logic [1:0] phase_o,
  // File memory access
  output logic [ADDR_W-1:0] file_addr_o,
  output logic file_rd_o,
  output logic file_we_o,
  output logic [7:0] file_wdata_o,
  // Working accumulator write
  output logic wreg_we_o,
  output logic [7:0] wreg_data_o,
  // Status flag write
  output logic status_we_o,
  output logic carry_flag_o,
  output logic digit_carry_flag_o,
  output logic negative_flag_o,
  output logic overflow_flag_o,
  output logic zero_flag_o,
  // Pipeline control
  output logic discard_o,
  output logic nop_cycle_o
);

  // ----------------------------------------
  // Decode function
  // ----------------------------------------
  // Maps opcode high field to an operation kind
  function automatic inc_exec_pkg::op_e decode_op(input logic [15:0] opc);
    inc_exec_pkg::op_e kind;
    kind = inc_exec_pkg::OP_NONE;
    if (opc[`OPC_HI_MSB:`OPC_HI_LSB] == `OPC_INC_FILE) begin
      kind = inc_exec_pkg::OP_INC;
    end else if (opc[`OPC_HI_MSB:`OPC_HI_LSB] == `OPC_INC_SKIP_Z) begin
      kind = inc_exec_pkg::OP_INC_SKIP_Z;
    end else if (opc[`OPC_HI_MSB:`OPC_HI_LSB] == `OPC_INC_SKIP_NZ) begin
      kind = inc_exec_pkg::OP_INC_SKIP_NZ;
    end
    return kind;
  endfunction : decode_op

  // ----------------------------------------
  // State
  // ----------------------------------------
  inc_exec_pkg::quarter_e q_r; // Current quarter
  inc_exec_pkg::quarter_e q_nxt; // Next quarter
  inc_exec_pkg::op_e op_r; // Operation in execution
  logic [15:0] opc_r; // Latched opcode
  logic two_word_r; // Next fetched word starts a two-word op
  logic [1:0] skip_left_r; // Nop cycles still to run
  logic [7:0] operand_r; // Captured file data
  logic [ADDR_W-1:0] addr_r; // Captured effective address

  // Registered outputs
  logic file_rd_r;
  logic file_we_r;
  logic [7:0] file_wdata_r;
  logic wreg_we_r;
  logic [7:0] wreg_data_r;
  logic status_we_r;
  logic [4:0] flags_r; // Carry, digit carry, negative, overflow, zero
  logic discard_r;
  logic nop_cycle_r;

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  logic [ADDR_W-1:0] eff_addr; // Effective file address
  logic [7:0] sum; // Incremented value
  logic c_f;
  logic digit_f;
  logic n_f;
  logic overflow_f;
  logic z_f;

  increment_datapath #(
    .ADDR_W(ADDR_W)
  ) increment_datapath_inst (
    .file_off_i(opc_r[`OPC_F_MSB:0]),
    .bank_acc_i(opc_r[`OPC_A_BIT]),
    .bank_sel_i(bank_select_pointer_i),
    .ext_set_en_i(ext_set_en_i),
    .index_base_i(index_base_i),
    .operand_i(operand_r),
    .addr_o(eff_addr),
    .sum_o(sum),
    .carry_o(c_f),
    .digit_carry_o(digit_f),
    .negative_o(n_f),
    .overflow_o(overflow_f),
    .zero_o(z_f)
  );

  // ----------------------------------------
  // Combinational decisions
  // ----------------------------------------
  // New instruction is taken at Q1 unless a skip is in progress
  wire logic in_skip = (skip_left_r != `SKIP_NONE);
  wire logic take = (q_r == inc_exec_pkg::Q1) && instr_valid_i && !in_skip;
  wire inc_exec_pkg::op_e new_op = take ? decode_op(instr_i) : inc_exec_pkg::OP_NONE;
  wire logic active = (op_r != inc_exec_pkg::OP_NONE);
  wire logic skip_z = (op_r == inc_exec_pkg::OP_INC_SKIP_Z) && z_f;
  wire logic skip_nz = (op_r == inc_exec_pkg::OP_INC_SKIP_NZ) && !z_f;
  wire logic do_skip = skip_z || skip_nz;
  wire logic [1:0] skip_count = two_word_r ? `SKIP_TWO : `SKIP_ONE;
  wire logic to_file = opc_r[`OPC_D_BIT];
  wire logic flag_upd = (op_r == inc_exec_pkg::OP_INC);
  wire logic at_q4 = (q_r == inc_exec_pkg::Q4);

  // ----------------------------------------
  // Quarter sequencer
  // ----------------------------------------
  // Quarters run freely Q1 to Q4
  always_comb begin
    unique case (q_r)
      inc_exec_pkg::Q1: q_nxt = inc_exec_pkg::Q2;
      inc_exec_pkg::Q2: q_nxt = inc_exec_pkg::Q3;
      inc_exec_pkg::Q3: q_nxt = inc_exec_pkg::Q4;
      inc_exec_pkg::Q4: q_nxt = inc_exec_pkg::Q1;
    endcase
  end

  // Quarter register
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      q_r <= inc_exec_pkg::Q1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ----------------------------------------
  // Instruction latch
  // ----------------------------------------
  // Opcode and next-word size held for the whole cycle
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      op_r <= inc_exec_pkg::OP_NONE;
      opc_r <= 16'h0000;
      two_word_r <= 1'b0;
    end else if (q_r == inc_exec_pkg::Q1) begin
      op_r <= new_op;
      opc_r <= take ? instr_i : opc_r;
      two_word_r <= take ? next_two_word_i : two_word_r;
    end
  end

  // ----------------------------------------
  // Read phase
  // ----------------------------------------
  // Q2 registers the address and read strobe, driven during Q3; Q3 captures the data
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      addr_r <= '0;
      file_rd_r <= 1'b0;
      operand_r <= `DATA_ZERO;
    end else begin
      file_rd_r <= active && (q_r == inc_exec_pkg::Q2);
      addr_r <= (active && q_r == inc_exec_pkg::Q2) ? eff_addr : addr_r;
      operand_r <= (active && q_r == inc_exec_pkg::Q3) ? file_rdata_i : operand_r;
    end
  end

  // ----------------------------------------
  // Write phase
  // ----------------------------------------
  // Result registered at Q4 and written as one-clock strobes in the following Q1
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      file_we_r <= 1'b0;
      file_wdata_r <= `DATA_ZERO;
      wreg_we_r <= 1'b0;
      wreg_data_r <= `DATA_ZERO;
    end else begin
      file_we_r <= active && at_q4 && to_file;
      file_wdata_r <= (active && at_q4) ? sum : file_wdata_r;
      wreg_we_r <= active && at_q4 && !to_file;
      wreg_data_r <= (active && at_q4) ? sum : wreg_data_r;
    end
  end

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  // Skip forms leave flags untouched
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      status_we_r <= 1'b0;
      flags_r <= 5'h00;
    end else begin
      status_we_r <= flag_upd && at_q4;
      flags_r <= (flag_upd && at_q4) ? {c_f, digit_f, n_f, overflow_f, z_f} : flags_r;
    end
  end

  // ----------------------------------------
  // Skip control
  // ----------------------------------------
  // Discard pulses in the Q1 after the skip's Q4; nop cycles counted down at each Q4
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      skip_left_r <= `SKIP_NONE;
      discard_r <= 1'b0;
    end else begin
      discard_r <= active && at_q4 && do_skip;
      if (active && at_q4 && do_skip) begin
        skip_left_r <= skip_count;
      end else if (at_q4 && in_skip) begin
        skip_left_r <= skip_left_r - `SKIP_ONE;
      end
    end
  end

  // Nop indicator follows the cycle boundary
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      nop_cycle_r <= 1'b0;
    end else begin
      nop_cycle_r <= (q_nxt == inc_exec_pkg::Q1) ? ((active && do_skip) || skip_left_r > `SKIP_ONE)
                                                 : (nop_cycle_r && in_skip);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign phase_o = q_r;
  assign file_addr_o = addr_r;
  assign file_rd_o = file_rd_r;
  assign file_we_o = file_we_r;
  assign file_wdata_o = file_wdata_r;
  assign wreg_we_o = wreg_we_r;
  assign wreg_data_o = wreg_data_r;
  assign status_we_o = status_we_r;
  assign carry_flag_o = flags_r[4];
  assign digit_carry_flag_o = flags_r[3];
  assign negative_flag_o = flags_r[2];
  assign overflow_flag_o = flags_r[1];
  assign zero_flag_o = flags_r[0];
  assign discard_o = discard_r;
  assign nop_cycle_o = nop_cycle_r;

endmodule : increment_skip_instr_exec
